//--- src/cst_decode_timer.sv
/*
  first-byte opcode decoder and execution state timer.
  assumes requests come from logic on the same clock, so no synchroniser.
*/
`timescale 1ns/100ps
// Overview of operation
// - the instruction class is taken from bits 15 to 8 of the first word.
// - push and pop have no own codes and decode as the matching move.
// - execution states are the sum of each cycle count times its cost.
// - fetch and on-chip ram byte access cost 2 states each.
// - branch address read and stack cycles cost 2 states each.
// - a byte access to a peripheral costs 2 or 3 states by module.
module cst_decode_timer
  import cst_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [15:0] i_insn_word,
  input wire cst_counts_s i_counts,
  input wire cst_target_s i_target,
  output logic o_ready,
  output logic o_busy,
  output logic o_done,
  output cst_class_e o_class,
  output logic o_stack_move,
  output logic [TOT_W-1:0] o_total_states
);
  typedef enum logic {S_IDLE, S_RUN} cst_state_e;

  cst_state_e state_q;
  logic [TOT_W-1:0] remain_q;
  logic [TOT_W-1:0] sum_w;
  logic [7:0] opc_w;
  logic accept_w;
  logic done_q;
  cst_class_e class_d;

  function automatic cst_class_e classify(input logic [7:0] opc);
    case (opc[7:4])
      4'h0: classify = CLS_MISC_CTL;
      4'h1: classify = CLS_ALU_SHIFT;
      4'h2, 4'h3: classify = CLS_MOVE;
      4'h4: classify = CLS_BRANCH;
      4'h5: classify = CLS_JUMP_CALL;
      // upper half of row 6 is moves, this covers the stack form too
      4'h6: classify = opc[3] ? CLS_MOVE : CLS_BIT_MANIP;
      4'h7: classify = CLS_BIT_MANIP;
      default: classify = CLS_ALU_IMM;
    endcase
  endfunction

  assign opc_w = i_insn_word[OPC_HI:OPC_LO];
  assign class_d = classify(opc_w);
  assign o_ready = (state_q == S_IDLE);
  assign o_busy = (state_q == S_RUN);
  assign o_done = done_q;
  assign accept_w = i_start && o_ready;

  cst_state_sum u_sum (
    .i_counts(i_counts),
    .i_target(i_target),
    .o_total(sum_w)
  );

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_class <= CLS_MISC_CTL;
      o_stack_move <= 1'b0;
      o_total_states <= TOTAL_RST;
    end else if (accept_w) begin
      o_class <= class_d;
      o_stack_move <= (opc_w == OPC_MOV_STACK);
      o_total_states <= sum_w;
    end
  end

  // one clock per state; a zero total finishes without entering run
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= S_IDLE;
      remain_q <= TOTAL_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (accept_w) begin
            remain_q <= sum_w;
            if (sum_w == TOTAL_RST) begin
              done_q <= 1'b1;
            end else begin
              state_q <= S_RUN;
            end
          end
        end
        S_RUN: begin
          remain_q <= remain_q - 8'h01;
          if (remain_q == 8'h01) begin
            state_q <= S_IDLE;
            done_q <= 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // helper: counts the clocks spent running, read only by checks
  logic [TOT_W-1:0] run_cnt_q;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_cnt_q <= TOTAL_RST;
    end else if (accept_w) begin
      run_cnt_q <= TOTAL_RST;
    end else if (o_busy) begin
      run_cnt_q <= run_cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_run_matches_total: assert property (
    o_done |-> run_cnt_q == o_total_states)
    else $error("run length differs from total states");
  a_stack_as_move: assert property (
    accept_w && opc_w == OPC_MOV_STACK |=> o_stack_move && o_class == CLS_MOVE)
    else $error("stack form not decoded as move");
  a_high_byte_class: assert property (
    accept_w && i_insn_word[15:12] == 4'h4 |=> o_class == CLS_BRANCH)
    else $error("class not taken from high byte");
  a_fetch_byte_cost: assert property (
    accept_w && !i_target.byte_to_periph && i_counts.braddr == 4'h0
      && i_counts.stack == 4'h0 && i_counts.word_acc == 4'h0
      && i_counts.internal == 4'h0
    |=> o_total_states == 8'(2 * ($past(i_counts.fetch) + $past(i_counts.byte_acc))))
    else $error("fetch or ram byte cost is not two");
  a_branch_stack_cost: assert property (
    accept_w && i_counts.byte_acc == 4'h0
      && i_counts.word_acc == 4'h0 && i_counts.internal == 4'h0
    |=> o_total_states == 8'(2 * ($past(i_counts.fetch) + $past(i_counts.braddr)
      + $past(i_counts.stack))))
    else $error("branch read or stack cost is not two");
  a_periph_slow_cost: assert property (
    accept_w && i_target.byte_to_periph && i_target.periph_slow
      && i_counts.braddr == 4'h0
      && i_counts.stack == 4'h0 && i_counts.word_acc == 4'h0
      && i_counts.internal == 4'h0
    |=> o_total_states == 8'(2 * $past(i_counts.fetch) + 3 * $past(i_counts.byte_acc)))
    else $error("slow peripheral byte cost is not three");
  a_periph_fast_cost: assert property (
    accept_w && i_target.byte_to_periph && !i_target.periph_slow
      && i_counts.braddr == 4'h0
      && i_counts.stack == 4'h0 && i_counts.word_acc == 4'h0
      && i_counts.internal == 4'h0
    |=> o_total_states == 8'(2 * ($past(i_counts.fetch) + $past(i_counts.byte_acc))))
    else $error("fast peripheral byte cost is not two");
  a_internal_one_state: assert property (
    accept_w && i_counts.braddr == 4'h0
      && i_counts.stack == 4'h0 && i_counts.byte_acc == 4'h0
      && i_counts.word_acc == 4'h0 && i_counts.internal != 4'h0
    |=> o_total_states == 8'(2 * $past(i_counts.fetch) + $past(i_counts.internal)))
    else $error("internal cycle not one state");
  a_ready_busy_excl: assert property (
    o_ready != o_busy)
    else $error("ready and busy overlap");

  // full weighted sum, written out from the cycle costs rather than the adder
  a_total_weighted_sum: assert property (
    accept_w |=> o_total_states == 8'(2 * ($past(i_counts.fetch) + $past(i_counts.braddr)
      + $past(i_counts.stack) + $past(i_counts.word_acc))
      + (($past(i_target.byte_to_periph) && $past(i_target.periph_slow)) ? 3 : 2)
      * $past(i_counts.byte_acc) + $past(i_counts.internal)))
    else $error("total is not the weighted sum of cycles");
  a_word_cost: assert property (
    accept_w && i_counts.braddr == 4'h0 && i_counts.stack == 4'h0
      && i_counts.byte_acc == 4'h0
    |=> o_total_states == 8'(2 * ($past(i_counts.fetch) + $past(i_counts.word_acc))
      + $past(i_counts.internal)))
    else $error("word access cost is not two");
  a_row_six_move: assert property (
    accept_w && opc_w[7:3] == 5'h0D |=> o_class == CLS_MOVE)
    else $error("upper half of row six not a move");
  a_stack_flag_exact: assert property (
    accept_w && opc_w != OPC_MOV_STACK |=> !o_stack_move)
    else $error("stack flag set for another opcode");
  a_alu_imm_class: assert property (
    accept_w && i_insn_word[15] |=> o_class == CLS_ALU_IMM)
    else $error("upper opcode half not immediate alu");

  // timing of the state count
  a_remain_loaded: assert property (
    accept_w |=> remain_q == o_total_states)
    else $error("state counter not loaded with total");
  a_busy_on_nonzero: assert property (
    accept_w && sum_w != TOTAL_RST |=> o_busy)
    else $error("nonzero total did not start counting");
  a_zero_total_done: assert property (
    accept_w && sum_w == TOTAL_RST |=> o_done && !o_busy)
    else $error("zero total did not finish at once");
  a_remain_counts_down: assert property (
    o_busy && remain_q != 8'h01 |=> o_busy && remain_q == $past(remain_q) - 8'h01)
    else $error("state counter did not step by one");
  a_done_after_busy: assert property (
    o_busy && remain_q == 8'h01 |=> o_done && o_ready)
    else $error("done missing after last state");
  a_ready_when_done: assert property (
    o_done |-> o_ready)
    else $error("done raised while not ready");

  // a request while counting is ignored; results stand until the next accept
  a_start_refused: assert property (
    o_busy && i_start |=> $stable(o_class) && $stable(o_total_states)
      && $stable(o_stack_move))
    else $error("request taken while busy");
  a_hold_when_idle: assert property (
    o_ready && !i_start |=> $stable(o_class) && $stable(o_total_states))
    else $error("results changed without a request");

  c_stack_move: cover property (accept_w && opc_w == OPC_MOV_STACK);
  c_slow_periph: cover property (accept_w && i_target.periph_slow
    && i_target.byte_to_periph && i_counts.byte_acc != 4'h0);
  c_run_done: cover property (o_busy ##1 o_done);
  c_zero_total: cover property (accept_w && sum_w == TOTAL_RST);
  c_busy_refused: cover property (o_busy && i_start);
endmodule

//--- common/cst_pkg.sv
/*
  shared types and constants for the opcode decoder and state timer.
  assumes one 100 MHz cpu clock; one cpu state is one clock cycle.
*/
package cst_pkg;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int CNT_W = 4;
  localparam int TOT_W = 8;

  // states per cycle of each type
  localparam logic [3:0] ST_FETCH = 4'h2;
  localparam logic [3:0] ST_BRADDR = 4'h2;
  localparam logic [3:0] ST_STACK = 4'h2;
  localparam logic [3:0] ST_BYTE_MEM = 4'h2;
  localparam logic [3:0] ST_BYTE_PERI_FAST = 4'h2;
  localparam logic [3:0] ST_BYTE_PERI_SLOW = 4'h3;
  localparam logic [3:0] ST_WORD = 4'h2;
  localparam logic [3:0] ST_INTERNAL = 4'h1;

  // first byte of the move form with pre-decrement / post-increment addressing
  localparam logic [7:0] OPC_MOV_STACK = 8'h6D;

  localparam logic [TOT_W-1:0] TOTAL_RST = 8'h00;
  localparam logic [7:0] OPC_RST = 8'h00;

  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] braddr;
    logic [CNT_W-1:0] stack;
    logic [CNT_W-1:0] byte_acc;
    logic [CNT_W-1:0] word_acc;
    logic [CNT_W-1:0] internal;
  } cst_counts_s;

  // where the byte accesses of an instruction land
  typedef struct packed {
    logic byte_to_periph;
    logic periph_slow;
  } cst_target_s;

  typedef enum logic [3:0] {
    CLS_MISC_CTL,
    CLS_ALU_SHIFT,
    CLS_MOVE,
    CLS_BRANCH,
    CLS_JUMP_CALL,
    CLS_BIT_MANIP,
    CLS_ALU_IMM
  } cst_class_e;
endpackage

//--- src/cst_state_sum.sv
/*
  combinational state-count adder: weights each cycle count by its cost.
  assumes counts and target flags are steady while they are read.
*/
`timescale 1ns/100ps
module cst_state_sum
  import cst_pkg::*;
(
  input wire cst_counts_s i_counts,
  input wire cst_target_s i_target,
  output logic [TOT_W-1:0] o_total
);
  function automatic logic [TOT_W-1:0] weigh(input logic [CNT_W-1:0] n,
                                             input logic [3:0] cost);
    // widen before the product so a full count does not wrap at four bits
    weigh = TOT_W'(n) * TOT_W'(cost);
  endfunction

  logic [3:0] byte_cost;

  always_comb begin
    if (!i_target.byte_to_periph) begin
      byte_cost = ST_BYTE_MEM;
    end else if (i_target.periph_slow) begin
      byte_cost = ST_BYTE_PERI_SLOW;
    end else begin
      byte_cost = ST_BYTE_PERI_FAST;
    end
  end

  // sum of the six weighted terms; max 15*12 fits 8 bits
  always_comb begin
    o_total = weigh(i_counts.fetch, ST_FETCH)
      + weigh(i_counts.braddr, ST_BRADDR)
      + weigh(i_counts.stack, ST_STACK)
      + weigh(i_counts.byte_acc, byte_cost)
      + weigh(i_counts.word_acc, ST_WORD)
      + weigh(i_counts.internal, ST_INTERNAL);
  end
endmodule

//--- testbench/cst_mem_model.sv
/*
  far-side model: cycle counts and access targets for a small instruction table.
  assumes the bench selects an entry and holds it while a request is taken.
*/
`timescale 1ns/100ps
module cst_mem_model
  import cst_pkg::*;
(
  input wire logic [2:0] i_sel,
  output cst_counts_s o_counts,
  output cst_target_s o_target
);
  // counts: fetch, braddr, stack, byte, word, internal
  always_comb begin
    o_target = 2'h0;
    case (i_sel)
      3'h0: o_counts = 24'h100000;
      3'h1: begin
        o_counts = 24'h200200;
        // slow flag without a peripheral target must not cost extra
        o_target = 2'h1;
      end
      3'h2: o_counts = 24'h211000;
      3'h3: begin
        o_counts = 24'h200100;
        o_target = 2'h3;
      end
      3'h4: begin
        o_counts = 24'h200100;
        o_target = 2'h2;
      end
      3'h5: o_counts = 24'h100003;
      3'h6: o_counts = 24'h100012;
      default: o_counts = 24'h000000;
    endcase
  end
endmodule

//--- testbench/cst_decode_timer_tb_top.sv
/*
  self-checking bench for the decoder and state timer.
  assumes the far-side model supplies counts and targets per entry.
*/
`timescale 1ns/100ps
module cst_decode_timer_tb_top
  import cst_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_start = 1'b0;
  logic [15:0] i_insn_word = 16'h0000;
  logic [2:0] sel = 3'h0;
  cst_counts_s counts;
  cst_target_s target;
  logic o_ready;
  logic o_busy;
  logic o_done;
  logic o_stack_move;
  cst_class_e o_class;
  logic [TOT_W-1:0] o_total_states;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 i_mclk = ~i_mclk;
  cst_mem_model u_mem (.i_sel(sel), .o_counts(counts), .o_target(target));
  cst_decode_timer u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(i_start),
    .i_insn_word(i_insn_word), .i_counts(counts), .i_target(target), .o_ready(o_ready),
    .o_busy(o_busy), .o_done(o_done), .o_class(o_class), .o_stack_move(o_stack_move),
    .o_total_states(o_total_states));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // poke raises a request while busy; it must leave the result alone
  task automatic run(input logic [2:0] s, input logic [15:0] w, input cst_class_e c,
                     input logic sm, input logic [7:0] t, input logic poke);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_start <= 1'b1;
    i_insn_word <= w;
    sel <= s;
    @(posedge i_mclk);
    i_start <= 1'b0;
    i_insn_word <= 16'h0000;
    #1;
    while (o_busy === 1'b1 && n < 40) begin
      chk("ready", 16'h0000, 16'(o_ready));
      n++;
      @(posedge i_mclk);
      i_start <= poke && n == 1 && t > 8'h02;
      #1;
    end
    chk("states", 16'(t), 16'(n));
    chk("done", 16'h0001, 16'(o_done));
    chk("class", 16'(c), 16'(o_class));
    chk("stack", 16'(sm), 16'(o_stack_move));
    chk("total", 16'(t), 16'(o_total_states));
    $display("test entry %0d done", s);
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    @(posedge i_mclk);
    #1;
    chk("rst ready", 16'h0001, 16'(o_ready));
    chk("rst busy", 16'h0000, 16'(o_busy));
    chk("rst total", 16'h0000, 16'(o_total_states));
    chk("rst done", 16'h0000, 16'(o_done));
    chk("rst class", 16'(CLS_MISC_CTL), 16'(o_class));
    chk("rst stack", 16'h0000, 16'(o_stack_move));
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    run(3'h0, 16'h8012, CLS_ALU_IMM, 1'b0, 8'h02, 1'b0);
    run(3'h1, 16'h7D00, CLS_BIT_MANIP, 1'b0, 8'h08, 1'b0);
    run(3'h2, 16'h5F30, CLS_JUMP_CALL, 1'b0, 8'h08, 1'b0);
    run(3'h3, 16'h6A10, CLS_MOVE, 1'b0, 8'h07, 1'b1);
    run(3'h4, 16'h2810, CLS_MOVE, 1'b0, 8'h06, 1'b0);
    run(3'h5, 16'h1000, CLS_ALU_SHIFT, 1'b0, 8'h05, 1'b1);
    run(3'h6, 16'h6D70, CLS_MOVE, 1'b1, 8'h06, 1'b0);
    run(3'h7, 16'h4000, CLS_BRANCH, 1'b0, 8'h00, 1'b0);
    results();
  end
endmodule
